/* verilog/conceal_defines.vh */
// Constants shared by the frame loss concealment controller.
`ifndef CONCEAL_DEFINES_VH
`define CONCEAL_DEFINES_VH

// Register byte offsets.
`define R_STATUS 8'h00
`define R_GAIN_L 8'h04
`define R_GAIN_R 8'h08
`define R_LPC_L 8'h0C
`define R_LPC_R 8'h10
`define R_LPC_MONO 8'h14
`define R_PEAK_PREV 8'h18
`define R_PEAK_CUR 8'h1C
`define R_BLK_EN 8'h20
`define R_RATIO 8'h24
`define R_EN_CUR 8'h28
`define R_EN_PREV 8'h2C
`define R_GAIN_OUT 8'h30
`define R_PH_DIFF 8'h34
`define R_RECIP_N 8'h38
`define R_PH_START 8'h3C
`define R_BIN_AMP 8'h40
`define R_BIN_PH 8'h44
`define R_OUT_AMP 8'h48
`define R_OUT_PH 8'h4C
`define R_LOSS_HIST 8'h50

// Mode indicator values.
`define MODE_ACELP 2'h0
`define MODE_SHORT 2'h1
`define MODE_MED 2'h2
`define MODE_LONG 2'h3
`define IND_NONE 3'h7
`define MODE_ALL_LONG 8'hFF

// Concealment limits.
`define MAX_LONG_LOSS 3'h2
`define DB_GAP 9'h014
`define Q_FRAC 4
`define RATIO_CAP 8'hA0
`define GAIN_CAP 8'hFF
`define SQRT_START 8'h80
`define BIN_LOST_BIT 16

`endif

/* verilog/frame_loss_concealment_ctrl.v */
// Frame loss concealment controller: mode extrapolation, downmix LP choice, spectral fill-in.
`timescale 1ns/10ps
`include "conceal_defines.vh"

module frame_loss_concealment_ctrl #(
    parameter HIST_DEPTH = 8
) (
    // Clock, reset and enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Superframe input from the demultiplexer
    input wire in_valid,
    output reg in_ready,
    input wire [3:0] in_bfi,
    input wire [7:0] in_mode_bits,
    // Resolved superframe output to synthesis
    output reg out_valid,
    input wire out_ready,
    output reg [7:0] out_mode,
    output reg [2:0] out_nloss,
    output reg [3:0] out_bfi,
    output reg out_loss_recent
);

    localparam ENTRY_W = 16;
    localparam HIST_W = 4 * HIST_DEPTH;
    function [2:0] count_loss;
        input [3:0] bfi;
        begin
            count_loss = {2'b00, bfi[0]} + {2'b00, bfi[1]} + {2'b00, bfi[2]} + {2'b00, bfi[3]};
        end
    endfunction
    function [7:0] resolve;
        input [3:0] bfi;
        input [7:0] bits;
        input [1:0] prev;
        reg [11:0] m;
        reg any_long;
        reg [2:0] n;
        reg [1:0] left;
        integer k;
        begin
            n = count_loss(bfi);
            any_long = 1'b0;
            m = 12'h000;
            for (k = 0; k < 4; k = k + 1) begin
                if (bfi[k]) begin
                    m[3*k +: 3] = `IND_NONE;
                end else begin
                    m[3*k +: 3] = {1'b0, bits[2*k +: 2]};
                    if (bits[2*k +: 2] == `MODE_LONG) begin
                        any_long = 1'b1;
                    end
                end
            end
            for (k = 0; k < 4; k = k + 1) begin
                if (any_long && n <= `MAX_LONG_LOSS && bfi[k]) begin
                    m[3*k +: 3] = {1'b0, `MODE_LONG};
                end else if (any_long && n > `MAX_LONG_LOSS) begin
                    m[3*k +: 3] = {1'b0, `MODE_SHORT};
                end
            end
            for (k = 0; k < 4; k = k + 1) begin
                if (bfi[k] && m[3*k +: 3] == `IND_NONE && !bfi[k ^ 1]
                        && m[3*(k ^ 1) +: 2] == `MODE_MED) begin
                    m[3*k +: 3] = {1'b0, `MODE_MED};
                end
            end
            left = prev;
            for (k = 0; k < 4; k = k + 1) begin
                if (m[3*k +: 3] == `IND_NONE) begin
                    m[3*k +: 3] = (left == `MODE_ACELP) ? {1'b0, `MODE_ACELP} :
                                  {1'b0, `MODE_SHORT};
                end
                left = m[3*k +: 2];
            end
            // Received indicators pass through as sent, unless a received long one meets more than two losses.
            resolve = {m[10:9], m[7:6], m[4:3], m[1:0]};
        end
    endfunction

    // Register file.
    reg [7:0] gain_l_q, gain_r_q;
    reg [15:0] lpc_l_q, lpc_r_q, lpc_mono_q;
    reg [15:0] peak_prev_q, peak_cur_q, blk_en_q, en_cur_q, en_prev_q;
    reg [7:0] ratio_q, gain_q;
    reg [15:0] ph_diff_q, recip_n_q, ph_acc_q, bin_amp_q, out_amp_q, out_ph_q;
    reg [HIST_W-1:0] hist_q;
    reg [1:0] prev_last_q;
    reg prev_long_q, long_pair_q;
    reg [7:0] last_mode_q;
    reg [2:0] last_nloss_q;
    // Square-root engine state.
    reg [15:0] num_q, den_q;
    reg [7:0] cap_q, res_q, bit_q;
    reg eng_gain_q;
    // Buffer spare entry.
    reg spare_v_q;
    reg [ENTRY_W-1:0] spare_q;
    wire access = psel && penable && !pready;
    wire wr_en = psel && penable && pready && pwrite;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [7:0] mode_new = resolve(in_bfi, in_mode_bits, prev_last_q);
    wire [2:0] nloss_new = count_loss(in_bfi);
    wire [ENTRY_W-1:0] entry_new = {nloss_new, in_bfi, mode_new, 1'b0};
    wire signed [8:0] db_diff = $signed({gain_l_q[7], gain_l_q}) -
                                $signed({gain_r_q[7], gain_r_q});
    wire [16:0] lpc_sum = {lpc_l_q[15], lpc_l_q} + {lpc_r_q[15], lpc_r_q};
    wire [15:0] peak_eff = (peak_cur_q < peak_prev_q) ? peak_prev_q : peak_cur_q;
    wire [7:0] ratio_cap = (ratio_q < `RATIO_CAP) ? ratio_q : `RATIO_CAP;
    wire [7:0] trial = res_q | bit_q;
    wire [15:0] trial_sq = trial * trial;
    wire [31:0] trial_prod = trial_sq * den_q;
    wire [31:0] num_scaled = {8'h00, num_q, 8'h00};
    wire signed [32:0] corr_prod = $signed(ph_diff_q) * $signed({1'b0, recip_n_q});
    wire [15:0] corr = corr_prod[31:16];
    wire [23:0] amp_prod = gain_q * bin_amp_q;
    wire [19:0] amp_scaled = amp_prod[23:`Q_FRAC];
    wire [15:0] amp_sat = (|amp_scaled[19:16]) ? 16'hFFFF : amp_scaled[15:0];
    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_err = 1'b0;
        case (paddr)
            `R_STATUS: rd_mux = {16'h0000, long_pair_q, |bit_q, 3'h0, last_nloss_q, last_mode_q};
            `R_GAIN_L: rd_mux = {24'h000000, gain_l_q};
            `R_GAIN_R: rd_mux = {24'h000000, gain_r_q};
            `R_LPC_L: rd_mux = {16'h0000, lpc_l_q};
            `R_LPC_R: rd_mux = {16'h0000, lpc_r_q};
            `R_LPC_MONO: rd_mux = {16'h0000, lpc_mono_q};
            `R_PEAK_PREV: rd_mux = {16'h0000, peak_prev_q};
            `R_PEAK_CUR: rd_mux = {16'h0000, peak_cur_q};
            `R_BLK_EN: rd_mux = {16'h0000, blk_en_q};
            `R_RATIO: rd_mux = {24'h000000, ratio_q};
            `R_EN_CUR: rd_mux = {16'h0000, en_cur_q};
            `R_EN_PREV: rd_mux = {16'h0000, en_prev_q};
            `R_GAIN_OUT: rd_mux = {24'h000000, gain_q};
            `R_PH_DIFF: rd_mux = {16'h0000, ph_diff_q};
            `R_RECIP_N: rd_mux = {16'h0000, recip_n_q};
            `R_PH_START: rd_mux = {16'h0000, ph_acc_q};
            `R_BIN_AMP: rd_mux = {16'h0000, bin_amp_q};
            `R_OUT_AMP: rd_mux = {16'h0000, out_amp_q};
            `R_OUT_PH: rd_mux = {16'h0000, out_ph_q};
            `R_LOSS_HIST: rd_mux = hist_q[31:0];
            `R_BIN_PH: rd_mux = 32'h00000000;
            default: begin
                rd_mux = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    // APB answers one cycle into the access phase, so pready is a plain flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= access;
            if (access) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= rd_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Software-written configuration and downmix choice.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_l_q <= 8'h00;
            gain_r_q <= 8'h00;
            lpc_l_q <= 16'h0000;
            lpc_r_q <= 16'h0000;
            lpc_mono_q <= 16'h0000;
            peak_prev_q <= 16'h0000;
            peak_cur_q <= 16'h0000;
            blk_en_q <= 16'h0000;
            en_cur_q <= 16'h0000;
            en_prev_q <= 16'h0000;
            ph_diff_q <= 16'h0000;
            recip_n_q <= 16'h0000;
            bin_amp_q <= 16'h0000;
        end else if (ce) begin
            if (db_diff > $signed(`DB_GAP)) begin
                lpc_mono_q <= lpc_l_q;
            end else if (db_diff < -$signed(`DB_GAP)) begin
                lpc_mono_q <= lpc_r_q;
            end else begin
                lpc_mono_q <= lpc_sum[16:1];
            end
            if (wr_en) begin
                case (paddr)
                    `R_GAIN_L: gain_l_q <= pwdata[7:0];
                    `R_GAIN_R: gain_r_q <= pwdata[7:0];
                    `R_LPC_L: lpc_l_q <= pwdata[15:0];
                    `R_LPC_R: lpc_r_q <= pwdata[15:0];
                    `R_PEAK_PREV: peak_prev_q <= pwdata[15:0];
                    `R_PEAK_CUR: peak_cur_q <= pwdata[15:0];
                    `R_BLK_EN: blk_en_q <= pwdata[15:0];
                    `R_EN_CUR: en_cur_q <= pwdata[15:0];
                    `R_EN_PREV: en_prev_q <= pwdata[15:0];
                    `R_PH_DIFF: ph_diff_q <= pwdata[15:0];
                    `R_RECIP_N: recip_n_q <= pwdata[15:0];
                    `R_BIN_AMP: bin_amp_q <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end
    // Bit-serial square root of num/den in Q4.4, eight cycles, clamped to cap.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            num_q <= 16'h0000;
            den_q <= 16'h0000;
            cap_q <= 8'h00;
            res_q <= 8'h00;
            bit_q <= 8'h00;
            eng_gain_q <= 1'b0;
            ratio_q <= `RATIO_CAP;
            gain_q <= 8'h00;
        end else if (ce) begin
            if (wr_en && paddr == `R_RATIO) begin
                ratio_q <= pwdata[7:0];
            end else if (wr_en && paddr == `R_BLK_EN && bit_q == 8'h00) begin
                num_q <= peak_eff;
                den_q <= pwdata[15:0];
                cap_q <= ratio_cap;
                res_q <= 8'h00;
                bit_q <= `SQRT_START;
                eng_gain_q <= 1'b0;
            end else if (wr_en && paddr == `R_EN_PREV && bit_q == 8'h00) begin
                num_q <= en_cur_q;
                den_q <= pwdata[15:0];
                cap_q <= `GAIN_CAP;
                res_q <= 8'h00;
                bit_q <= `SQRT_START;
                eng_gain_q <= 1'b1;
            end else if (bit_q != 8'h00) begin
                if (trial <= cap_q && trial_prod <= num_scaled) begin
                    res_q <= trial;
                end
                bit_q <= bit_q >> 1;
                if (bit_q[0]) begin
                    if (eng_gain_q) begin
                        gain_q <= (trial <= cap_q && trial_prod <= num_scaled) ? trial : res_q;
                    end else begin
                        ratio_q <= (trial <= cap_q && trial_prod <= num_scaled) ?
                                   trial : res_q;
                    end
                end
            end
        end
    end
    // Per-bin merge of received and extrapolated coefficients.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_acc_q <= 16'h0000;
            out_amp_q <= 16'h0000;
            out_ph_q <= 16'h0000;
        end else if (ce) begin
            if (wr_en && paddr == `R_PH_START) begin
                ph_acc_q <= pwdata[15:0];
            end else if (wr_en && paddr == `R_BIN_PH) begin
                if (pwdata[`BIN_LOST_BIT] && long_pair_q) begin
                    out_amp_q <= amp_sat;
                    out_ph_q <= ph_acc_q + pwdata[15:0] + corr;
                    ph_acc_q <= ph_acc_q + pwdata[15:0] + corr;
                end else if (pwdata[`BIN_LOST_BIT]) begin
                    // Unless an all-long superframe with losses follows an all-long one, there is no history worth trusting.
                    out_amp_q <= 16'h0000;
                    out_ph_q <= 16'h0000;
                end else begin
                    out_amp_q <= bin_amp_q;
                    out_ph_q <= pwdata[15:0];
                    ph_acc_q <= pwdata[15:0];
                end
            end
        end
    end
    // Superframe resolution, history and the two-entry output buffer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_last_q <= `MODE_ACELP;
            prev_long_q <= 1'b0;
            long_pair_q <= 1'b0;
            last_mode_q <= 8'h00;
            last_nloss_q <= 3'h0;
            hist_q <= {HIST_W{1'b0}};
            spare_v_q <= 1'b0;
            spare_q <= {ENTRY_W{1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
            out_mode <= 8'h00;
            out_nloss <= 3'h0;
            out_bfi <= 4'h0;
            out_loss_recent <= 1'b0;
        end else if (ce) begin
            if (push) begin
                prev_last_q <= mode_new[7:6];
                prev_long_q <= (mode_new == `MODE_ALL_LONG);
                long_pair_q <= prev_long_q && (mode_new == `MODE_ALL_LONG)
                               && (nloss_new != 3'h0);
                last_mode_q <= mode_new;
                last_nloss_q <= nloss_new;
                hist_q <= {hist_q[HIST_W-5:0], in_bfi};
            end
            // The spare entry absorbs one word when the receiver stalls.
            if (!out_valid || pop) begin
                if (spare_v_q) begin
                    out_valid <= 1'b1;
                    {out_nloss, out_bfi, out_mode, out_loss_recent} <= spare_q;
                    spare_v_q <= push;
                    in_ready <= !push;
                    if (push) begin
                        spare_q <= {entry_new[ENTRY_W-1:1], |hist_q};
                    end
                end else begin
                    out_valid <= push;
                    in_ready <= 1'b1;
                    if (push) begin
                        {out_nloss, out_bfi, out_mode, out_loss_recent} <=
                            {entry_new[ENTRY_W-1:1], |hist_q};
                    end
                end
            end else begin
                if (push) begin
                    spare_q <= {entry_new[ENTRY_W-1:1], |hist_q};
                    spare_v_q <= 1'b1;
                    in_ready <= 1'b0;
                end else begin
                    in_ready <= !spare_v_q;
                end
            end
        end
    end
endmodule // frame_loss_concealment_ctrl

/* verif/concealment_checker.sv */
// Concurrent checks on the ports of the concealment controller.
`timescale 1ns/10ps
module concealment_checker #(
    parameter HIST_DEPTH = 8
) (
    // Clock, reset and enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Register bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Input stream
    input wire in_valid,
    input wire in_ready,
    input wire [3:0] in_bfi,
    input wire [7:0] in_mode_bits,
    // Output stream
    input wire out_valid,
    input wire out_ready,
    input wire [7:0] out_mode,
    input wire [2:0] out_nloss,
    input wire [3:0] out_bfi,
    input wire out_loss_recent
);
    wire [3:0] m3;
    wire [3:0] m2;
    wire avail3;
    wire half_miss;
    wire choice_miss;
    reg [1:0] fill_q;
    reg [1:0] fill_d;
    wire lone_new;
    reg [1:0] lone_q;
    reg [1:0] lone_d;

    assign m3 = {&out_mode[7:6], &out_mode[5:4], &out_mode[3:2], &out_mode[1:0]};
    assign m2 = {out_mode[7:6] == 2'h2, out_mode[5:4] == 2'h2, out_mode[3:2] == 2'h2,
        out_mode[1:0] == 2'h2};
    assign avail3 = |(m3 & ~out_bfi);
    // Partner of frame k is frame k^1, so the swapped vectors line up the halves.
    assign half_miss = !avail3 && |(m2 & ~out_bfi & {out_bfi[2], out_bfi[3], out_bfi[0],
        out_bfi[1]} & ~{m2[2], m2[3], m2[0], m2[1]});
    assign choice_miss = (out_bfi[1] && !out_mode[3] && (out_mode[2] != (out_mode[1:0] != 2'h0)))
        || (out_bfi[2] && !out_mode[5] && (out_mode[4] != (out_mode[3:2] != 2'h0)))
        || (out_bfi[3] && !out_mode[7] && (out_mode[6] != (out_mode[5:4] != 2'h0)));

    // The output hides a lone long indicator, so it is remembered per held word.
    assign lone_new = $countones(in_bfi) == 3 && |(~in_bfi & {&in_mode_bits[7:6],
        &in_mode_bits[5:4], &in_mode_bits[3:2], &in_mode_bits[1:0]});

    // Words held by the controller; a frozen enable takes nothing.
    always @* begin
        fill_d = fill_q;
        lone_d = lone_q;
        if (ce && out_valid && out_ready) begin
            fill_d = fill_d - 2'h1;
            lone_d = {1'b0, lone_d[1]};
        end
        if (ce && in_valid && in_ready) begin
            lone_d[fill_d[0]] = lone_new;
            fill_d = fill_d + 2'h1;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q <= 2'h0;
            lone_q <= 2'h0;
        end else begin
            fill_q <= fill_d;
            lone_q <= lone_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("pready stayed high");
    a_ready_answer: assert property (psel && penable && !pready && ce |=> pready)
        else $error("no answer one cycle into the access phase");
    a_unmapped_err: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > 8'h50) && (!pslverr || prdata == 32'h0))
        else $error("error response does not match the address map");
    a_lost_count: assert property (out_valid |-> out_nloss == $countones(out_bfi))
        else $error("lost count differs from loss flags");
    a_word_held: assert property (out_valid && !out_ready |=> out_valid &&
        $stable({out_mode, out_nloss, out_bfi, out_loss_recent}))
        else $error("output word changed while stalled");
    a_long_fill: assert property (out_valid && avail3 && out_nloss <= 3'h2 |->
        out_mode == 8'hFF) else $error("available long indicator not spread");
    a_lone_long: assert property (out_valid && lone_q[0] |-> out_mode == 8'h55)
        else $error("heavy loss did not fall back to short frames");
    a_half_partner: assert property (out_valid |-> !half_miss)
        else $error("medium partner not filled");
    a_zero_one: assert property (out_valid |-> !choice_miss)
        else $error("wrong choice between zero and one");
    a_buffer_full: assert property (fill_q == 2'h2 |-> !in_ready)
        else $error("input accepted with both entries full");
    a_word_shown: assert property (fill_q != 2'h0 |-> out_valid)
        else $error("held word not presented");
endmodule // concealment_checker

bind frame_loss_concealment_ctrl concealment_checker #(.HIST_DEPTH(HIST_DEPTH)) chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_bfi(in_bfi),
    .in_mode_bits(in_mode_bits), .out_valid(out_valid), .out_ready(out_ready),
    .out_mode(out_mode), .out_nloss(out_nloss), .out_bfi(out_bfi),
    .out_loss_recent(out_loss_recent));

/* verif/synth_sink.sv */
// Model of the synthesis stage that takes resolved superframe words.
`timescale 1ns/10ps
module synth_sink (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Resolved words
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [7:0] out_mode,
    input wire logic [2:0] out_nloss,
    input wire logic [3:0] out_bfi,
    input wire logic out_loss_recent,
    // Pace control
    input wire logic stall,
    input wire logic slow
);
    logic [15:0] got[$];
    logic tick;

    // Ready is registered, so a slow sink drops it every other cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
            tick <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                got.push_back({out_mode, out_nloss, out_bfi, out_loss_recent});
            end
            tick <= ~tick;
            out_ready <= !stall && (!slow || tick);
        end
    end
endmodule // synth_sink

/* verif/test_frame_loss_concealment_ctrl.sv */
// Self-checking bench for the frame loss concealment controller.
`timescale 1ns/10ps
`include "conceal_defines.vh"
module test_frame_loss_concealment_ctrl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic in_valid = 1'b0;
    logic [3:0] in_bfi = 4'h0;
    logic [7:0] in_mode_bits = 8'h00;
    logic stall = 1'b0;
    logic slow = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, in_ready, out_valid, out_ready, out_loss_recent;
    wire [7:0] out_mode;
    wire [2:0] out_nloss;
    wire [3:0] out_bfi;
    logic [31:0] rd;
    logic err;
    logic [31:0] hist = 32'h0;
    logic [15:0] expq[$];
    int n_mismatch = 0;
    int n_checks = 0;

    always #5 pclk = ~pclk;

    frame_loss_concealment_ctrl #(.HIST_DEPTH(8)) DUT (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_valid(in_valid), .in_ready(in_ready), .in_bfi(in_bfi),
        .in_mode_bits(in_mode_bits), .out_valid(out_valid), .out_ready(out_ready),
        .out_mode(out_mode), .out_nloss(out_nloss), .out_bfi(out_bfi),
        .out_loss_recent(out_loss_recent));
    synth_sink sink (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
        .out_ready(out_ready), .out_mode(out_mode), .out_nloss(out_nloss),
        .out_bfi(out_bfi), .out_loss_recent(out_loss_recent), .stall(stall), .slow(slow));

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task hang;
        check(32'h0, 32'h1);
        end_of_test;
    endtask

    // One idle cycle precedes each setup, so psel is never driven twice in a step.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) hang;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task wait_idle;
        int i;
        i = 0;
        do begin
            apb(1'b0, `R_STATUS, 32'h0);
            i++;
        end while (rd[14] !== 1'b0 && i < 30);
        if (rd[14] !== 1'b0) hang;
    endtask

    task send(input logic [3:0] b, input logic [7:0] m, input logic [7:0] e);
        int i;
        @(posedge pclk);
        in_valid <= 1'b1;
        in_bfi <= b;
        in_mode_bits <= m;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (in_ready !== 1'b1 && i < 50);
        if (in_ready !== 1'b1) hang;
        in_valid <= 1'b0;
        expq.push_back({e, 3'($countones(b)), b, |hist});
        hist = {hist[27:0], b};
    endtask

    task drain;
        int i;
        i = 0;
        while (expq.size() > 0 && i < 200) begin
            @(negedge pclk);
            i++;
            while (sink.got.size() > 0 && expq.size() > 0)
                check(sink.got.pop_front(), expq.pop_front());
        end
        if (expq.size() > 0) hang;
    endtask

    task t_reset;
        rchk(`R_STATUS, 32'h0);
        rchk(`R_RATIO, 32'hA0);
        rchk(`R_LOSS_HIST, 32'h0);
        apb(1'b1, 8'h60, 32'h1);
        check({31'h0, err}, 32'h1);
        rchk(8'h60, 32'h0);
        $display("reset test done");
    endtask

    task mix(input logic [7:0] gl, input logic [7:0] gr, input logic [31:0] exp);
        apb(1'b1, `R_GAIN_L, {24'h0, gl});
        apb(1'b1, `R_GAIN_R, {24'h0, gr});
        rchk(`R_LPC_MONO, exp);
    endtask

    task t_downmix;
        apb(1'b1, `R_LPC_L, 32'h1000);
        apb(1'b1, `R_LPC_R, 32'h3000);
        mix(8'h1E, 8'h05, 32'h1000);
        mix(8'hF0, 8'h05, 32'h3000);
        mix(8'hF6, 8'h0A, 32'h2000);
        mix(8'h00, 8'h13, 32'h2000);
        $display("downmix test done");
    endtask

    task t_modes;
        @(posedge pclk);
        stall <= 1'b1;
        send(4'h0, 8'hA4, 8'hA4);
        send(4'h5, 8'hDD, 8'hFF);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check({31'h0, in_ready}, 32'h0);
        @(posedge pclk);
        stall <= 1'b0;
        slow <= 1'b1;
        send(4'hE, 8'hAB, 8'h55);
        send(4'h2, 8'h42, 8'h4A);
        send(4'h8, 8'h90, 8'h50);
        send(4'h1, 8'h03, 8'h01);
        send(4'h0, 8'h00, 8'h00);
        send(4'hF, 8'hFF, 8'h00);
        send(4'h4, 8'h05, 8'h15);
        send(4'h8, 8'h20, 8'hA0);
        drain;
        @(posedge pclk);
        slow <= 1'b0;
        rchk(`R_LOSS_HIST, hist);
        $display("mode test done");
    endtask

    task ratio(input logic [31:0] seed, pp, pc, blk, exp);
        apb(1'b1, `R_RATIO, seed);
        apb(1'b1, `R_PEAK_PREV, pp);
        apb(1'b1, `R_PEAK_CUR, pc);
        apb(1'b1, `R_BLK_EN, blk);
        wait_idle;
        rchk(`R_RATIO, exp);
    endtask

    task t_ratio;
        ratio(32'hFF, 32'd400, 32'd100, 32'd4, 32'hA0);
        ratio(32'hFF, 32'd0, 32'd1600, 32'd4, 32'hA0);
        ratio(32'h30, 32'd16, 32'd16, 32'd1, 32'h30);
        ratio(32'hFF, 32'd0, 32'd36, 32'd4, 32'h30);
        // A low enable must hold the engine part way, so it is still busy afterwards.
        apb(1'b1, `R_BLK_EN, 32'd4);
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, `R_STATUS, 32'h0);
        check({31'h0, rd[14]}, 32'h1);
        wait_idle;
        rchk(`R_RATIO, 32'h30);
        $display("ratio test done");
    endtask

    task bin(input logic [31:0] amp, ph, ea, ep);
        apb(1'b1, `R_BIN_AMP, amp);
        apb(1'b1, `R_BIN_PH, ph);
        rchk(`R_OUT_AMP, ea);
        rchk(`R_OUT_PH, ep);
    endtask

    task t_spectrum;
        send(4'h0, 8'hFF, 8'hFF);
        send(4'h1, 8'hFC, 8'hFF);
        drain;
        rchk(`R_STATUS, 32'h81FF);
        apb(1'b1, `R_EN_CUR, 32'd400);
        apb(1'b1, `R_EN_PREV, 32'd100);
        wait_idle;
        rchk(`R_GAIN_OUT, 32'h20);
        apb(1'b1, `R_PH_START, 32'h100);
        apb(1'b1, `R_PH_DIFF, 32'h40);
        apb(1'b1, `R_RECIP_N, 32'h4000);
        bin(32'h50, 32'h10020, 32'hA0, 32'h130);
        bin(32'h50, 32'h10008, 32'hA0, 32'h148);
        bin(32'h33, 32'h0777, 32'h33, 32'h777);
        send(4'h0, 8'h00, 8'h00);
        drain;
        bin(32'h50, 32'h10008, 32'h0, 32'h0);
        $display("spectrum test done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset;
        t_downmix;
        t_modes;
        t_ratio;
        t_spectrum;
        end_of_test;
    end
endmodule // test_frame_loss_concealment_ctrl
